// ==== psdt_seq.sv ====
// power sequence delay timer: sequencer, APB registers and interrupt
// assumes uvlo_ok_i and wake_pin_i are synchronous to mclk_i, and that a
// host command forwarded from the serial port arrives as an APB write
module psdt_seq #(
  parameter int TICK_CYCLES = psdt_pkg::TICK_CYCLES, // shorten for simulation
  parameter logic FACTORY_ON_MSB = 1'b1, // factory top bit, startup code
  parameter logic FACTORY_OFF_MSB = 1'b1 // factory top bit, turn-off code
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // supply and wake
  input wire logic uvlo_ok_i,
  input wire logic wake_pin_i,
  // sequencing outputs
  output logic por_released_o,
  output logic rail_on_o,
  output logic system_reset_out_n_o,
  output logic deep_sleep_state_o,
  // thermal warning select
  output logic [1:0] thermal_warning_level_o,
  output logic [3:0] warn_select_o,
  // interrupt
  output logic irq_o
);

  // bounds for the latency checks, in clock cycles
  localparam int US_CYC = psdt_pkg::US_TICKS * TICK_CYCLES;
  localparam int POR_MAX_CYC = psdt_pkg::POR_LIMIT_US * US_CYC;
  localparam int START_MAX_CYC = psdt_pkg::START_LIMIT_US * US_CYC;
  localparam int DEEP_MAX_CYC = psdt_pkg::DEEP_EXIT_LIMIT_MS * 1000 * US_CYC;
  localparam int SLEEP_MAX_CYC = psdt_pkg::SLEEP_EXIT_LIMIT_US * US_CYC;
  localparam int OFF_MAX_CYC = psdt_pkg::OFF_LIMIT_US * US_CYC;

  psdt_pkg::psdt_state_t state_r; // sequencer state
  psdt_pkg::psdt_state_t state_nxt;
  psdt_pkg::psdt_ctrl_t ctrl_r; // programmed codes
  psdt_pkg::psdt_irq_t irq_stat_r; // sticky events
  psdt_pkg::psdt_irq_t irq_mask_r; // event enables
  psdt_pkg::psdt_irq_t irq_ev; // events this cycle
  logic deep_r; // pending entry is deep sleep
  logic sleep_cmd_r; // one-cycle command pulses
  logic deep_cmd_r;
  logic exit_cmd_r;
  logic wake_d_r; // last wake pin level
  logic wake_edge; // any wake pin transition
  logic tick; // shared timebase
  logic tmr_load;
  logic [psdt_pkg::TW-1:0] tmr_val;
  logic tmr_done;
  logic setup; // apb setup phase
  logic wr_en; // apb write takes effect
  logic mapped; // address decodes to a register
  logic [31:0] rd_mux;
  logic [31:0] seq_cnt_r; // cycles in current state, checks only
  logic [31:0] up_cnt_r; // cycles since supply good or last wake, checks only

  // shared timebase and the one sequencing delay counter
  psdt_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .restart_i(tmr_load),
    .tick_o(tick)
  );

  psdt_timer u_timer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .load_i(tmr_load),
    .load_val_i(tmr_val),
    .tick_i(tick),
    .done_o(tmr_done)
  );

  // wake pin transition, either direction
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wake_d_r <= 1'b0;
    end else begin
      wake_d_r <= wake_pin_i;
    end
  end
  assign wake_edge = wake_pin_i ^ wake_d_r;

  // sequencer next state; supply loss overrides everything
  always_comb begin
    state_nxt = state_r;
    tmr_load = 1'b0;
    tmr_val = '0;
    if (!uvlo_ok_i) begin
      state_nxt = psdt_pkg::S_OFF;
    end else begin
      unique case (state_r)
        psdt_pkg::S_OFF: begin
          // hold power-on clear for a fixed time under the limit
          state_nxt = psdt_pkg::S_POR;
          tmr_load = 1'b1;
          tmr_val = psdt_pkg::us_ticks(psdt_pkg::POR_DELAY_US * 10);
        end
        psdt_pkg::S_POR: begin
          if (tmr_done) begin
            state_nxt = psdt_pkg::S_ON_DLY;
            tmr_load = 1'b1;
            tmr_val = psdt_pkg::dly_ticks(ctrl_r.on_code);
          end
        end
        psdt_pkg::S_ON_DLY: begin
          if (tmr_done) begin
            state_nxt = psdt_pkg::S_RST_DLY;
            tmr_load = 1'b1;
            tmr_val = psdt_pkg::rst_ticks(ctrl_r.rst_code);
          end
        end
        psdt_pkg::S_RST_DLY: begin
          if (tmr_done) begin
            state_nxt = psdt_pkg::S_ACTIVE;
          end
        end
        psdt_pkg::S_ACTIVE: begin
          // turn-off event starts the off delay
          if (sleep_cmd_r || deep_cmd_r) begin
            state_nxt = psdt_pkg::S_OFF_DLY;
            tmr_load = 1'b1;
            tmr_val = psdt_pkg::dly_ticks(ctrl_r.off_code);
          end
        end
        psdt_pkg::S_OFF_DLY: begin
          if (tmr_done) begin
            state_nxt = deep_r ? psdt_pkg::S_DEEP : psdt_pkg::S_SLEEP;
          end
        end
        psdt_pkg::S_SLEEP: begin
          // only the host command ends sleep
          if (exit_cmd_r) begin
            state_nxt = psdt_pkg::S_ON_DLY;
            tmr_load = 1'b1;
            tmr_val = psdt_pkg::dly_ticks(ctrl_r.on_code);
          end
        end
        psdt_pkg::S_DEEP: begin
          // only a wake pin ends deep sleep
          if (wake_edge) begin
            state_nxt = psdt_pkg::S_ON_DLY;
            tmr_load = 1'b1;
            tmr_val = psdt_pkg::dly_ticks(ctrl_r.on_code);
          end
        end
      endcase
    end
  end

  // state register and the deep/plain choice of the pending entry
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= psdt_pkg::S_OFF;
      deep_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == psdt_pkg::S_ACTIVE && (sleep_cmd_r || deep_cmd_r)) begin
        deep_r <= deep_cmd_r; // deep wins if both arrive together
      end
    end
  end

  // sequencing outputs follow the next state so they are flop-driven
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      por_released_o <= 1'b0;
      rail_on_o <= 1'b0;
      system_reset_out_n_o <= 1'b0;
      deep_sleep_state_o <= 1'b0;
    end else begin
      por_released_o <= state_nxt != psdt_pkg::S_OFF && state_nxt != psdt_pkg::S_POR;
      rail_on_o <= state_nxt inside {psdt_pkg::S_RST_DLY, psdt_pkg::S_ACTIVE,
                                     psdt_pkg::S_OFF_DLY};
      system_reset_out_n_o <= state_nxt == psdt_pkg::S_ACTIVE;
      deep_sleep_state_o <= state_nxt == psdt_pkg::S_DEEP;
    end
  end

  // warning level and its threshold select
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      thermal_warning_level_o <= psdt_pkg::THERMAL_WARNING_LEVEL_RST;
      warn_select_o <= psdt_pkg::thermal_warning_level_onehot(psdt_pkg::THERMAL_WARNING_LEVEL_RST);
    end else begin
      thermal_warning_level_o <= ctrl_r.thermal_warning_level;
      warn_select_o <= psdt_pkg::thermal_warning_level_onehot(ctrl_r.thermal_warning_level);
    end
  end

  // apb decode; zero wait states, so ready is the registered setup phase
  assign setup = psel_i && !penable_i;
  assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
  assign mapped = paddr_i inside {psdt_pkg::ADDR_CTRL, psdt_pkg::ADDR_CMD,
                                  psdt_pkg::ADDR_STATUS, psdt_pkg::ADDR_IRQ_STAT,
                                  psdt_pkg::ADDR_IRQ_MASK};

  // read data; command register reads as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr_i)
      // bit 11 is a hole, so the level sits at its own position
      psdt_pkg::ADDR_CTRL: rd_mux[15:0] = {2'h0, ctrl_r.thermal_warning_level, 1'b0, ctrl_r.rst_code,
                                           ctrl_r.off_code, ctrl_r.on_code};
      psdt_pkg::ADDR_STATUS: rd_mux[7:0] = {1'b0, deep_sleep_state_o,
                                            system_reset_out_n_o, rail_on_o,
                                            por_released_o, state_r};
      psdt_pkg::ADDR_IRQ_STAT: rd_mux[3:0] = irq_stat_r;
      psdt_pkg::ADDR_IRQ_MASK: rd_mux[3:0] = irq_mask_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // answer is prepared in setup and shown through the access phase
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup && !mapped;
      prdata_o <= (setup && !pwrite_i) ? rd_mux : 32'h0000_0000;
    end
  end

  // settings; the top code bits come from the factory, never from software
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl_r.on_code <= {FACTORY_ON_MSB, psdt_pkg::ON_LOW_RST};
      ctrl_r.off_code <= {FACTORY_OFF_MSB, psdt_pkg::OFF_LOW_RST};
      ctrl_r.rst_code <= psdt_pkg::RST_CODE_RST;
      ctrl_r.thermal_warning_level <= psdt_pkg::THERMAL_WARNING_LEVEL_RST;
    end else if (wr_en && paddr_i == psdt_pkg::ADDR_CTRL) begin
      ctrl_r.on_code <= {FACTORY_ON_MSB, pwdata_i[psdt_pkg::CTRL_ON_LSB +: 3]};
      ctrl_r.off_code <= {FACTORY_OFF_MSB, pwdata_i[psdt_pkg::CTRL_OFF_LSB +: 3]};
      ctrl_r.rst_code <= pwdata_i[psdt_pkg::CTRL_RST_LSB +: 3];
      ctrl_r.thermal_warning_level <= pwdata_i[psdt_pkg::CTRL_THERMAL_WARNING_LEVEL_LSB +: 2];
    end
  end

  // command pulses last one cycle; outside their state they are dropped
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sleep_cmd_r <= 1'b0;
      deep_cmd_r <= 1'b0;
      exit_cmd_r <= 1'b0;
    end else begin
      sleep_cmd_r <= wr_en && paddr_i == psdt_pkg::ADDR_CMD &&
                     pwdata_i[psdt_pkg::CMD_SLEEP_BIT];
      deep_cmd_r <= wr_en && paddr_i == psdt_pkg::ADDR_CMD &&
                    pwdata_i[psdt_pkg::CMD_DEEP_BIT];
      exit_cmd_r <= wr_en && paddr_i == psdt_pkg::ADDR_CMD &&
                    pwdata_i[psdt_pkg::CMD_EXIT_BIT];
    end
  end

  // events, taken from the transitions the outputs are about to make
  always_comb begin
    irq_ev.por_done = state_r == psdt_pkg::S_POR && state_nxt == psdt_pkg::S_ON_DLY;
    irq_ev.rail_on = state_r == psdt_pkg::S_ON_DLY && state_nxt == psdt_pkg::S_RST_DLY;
    irq_ev.rail_off = rail_on_o && !(state_nxt inside {psdt_pkg::S_RST_DLY,
                      psdt_pkg::S_ACTIVE, psdt_pkg::S_OFF_DLY});
    irq_ev.rst_released = state_r == psdt_pkg::S_RST_DLY && state_nxt == psdt_pkg::S_ACTIVE;
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
    end else if (wr_en && paddr_i == psdt_pkg::ADDR_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~pwdata_i[3:0]) | irq_ev;
    end else begin
      irq_stat_r <= irq_stat_r | irq_ev;
    end
  end

  // mask register and the level interrupt
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_mask_r <= psdt_pkg::IRQ_MASK_RST;
      irq_o <= 1'b0;
    end else begin
      if (wr_en && paddr_i == psdt_pkg::ADDR_IRQ_MASK) begin
        irq_mask_r <= pwdata_i[3:0];
      end
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // cycle counters that only the checks below read
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      seq_cnt_r <= 32'h0000_0000;
      up_cnt_r <= 32'h0000_0000;
    end else begin
      seq_cnt_r <= (state_nxt != state_r) ? 32'h0000_0000 : seq_cnt_r + 32'h0000_0001;
      // restarts in every state that a start-up leaves from
      up_cnt_r <= (state_r inside {psdt_pkg::S_OFF, psdt_pkg::S_SLEEP, psdt_pkg::S_DEEP}) ?
                  32'h0000_0000 : up_cnt_r + 32'h0000_0001;
    end
  end

  a_por_release_bound: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_r == psdt_pkg::S_POR |-> seq_cnt_r <= POR_MAX_CYC)
    else $error("power-on clear held too long");

  a_first_rail_bound: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_r inside {psdt_pkg::S_POR, psdt_pkg::S_ON_DLY} && ctrl_r.on_code == 4'h8)
    |-> up_cnt_r <= START_MAX_CYC)
    else $error("first rail late after supply good");

  a_wake_exit_bound: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_r == psdt_pkg::S_ON_DLY && deep_r && ctrl_r.on_code inside {4'h0, 4'h1, 4'h8})
    |-> up_cnt_r <= DEEP_MAX_CYC)
    else $error("deep sleep exit too slow");

  a_sleep_exit_bound: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_r == psdt_pkg::S_ON_DLY && ctrl_r.on_code inside {4'h0, 4'h1, 4'h8})
    |-> seq_cnt_r <= SLEEP_MAX_CYC)
    else $error("sleep exit too slow");

  a_off_entry_bound: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_r == psdt_pkg::S_OFF_DLY && ctrl_r.off_code inside {4'h0, 4'h1, 4'h8})
    |-> seq_cnt_r <= OFF_MAX_CYC)
    else $error("first rail off too late");

  a_on_delay_length: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_r == psdt_pkg::S_ON_DLY && state_nxt == psdt_pkg::S_RST_DLY)
    |-> seq_cnt_r >= int'(psdt_pkg::dly_ticks(ctrl_r.on_code)) * (TICK_CYCLES - 1) &&
        seq_cnt_r <= (int'(psdt_pkg::dly_ticks(ctrl_r.on_code)) + 1) * TICK_CYCLES + 4)
    else $error("startup delay length wrong");

  a_off_delay_length: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_r == psdt_pkg::S_OFF_DLY && state_nxt != psdt_pkg::S_OFF_DLY && uvlo_ok_i)
    |-> seq_cnt_r >= int'(psdt_pkg::dly_ticks(ctrl_r.off_code)) * (TICK_CYCLES - 1) &&
        seq_cnt_r <= (int'(psdt_pkg::dly_ticks(ctrl_r.off_code)) + 1) * TICK_CYCLES + 4)
    else $error("turn-off delay length wrong");

  a_reset_release_len: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(system_reset_out_n_o)
    |-> $past(state_r) == psdt_pkg::S_RST_DLY &&
        $past(seq_cnt_r) >= int'(psdt_pkg::rst_ticks(ctrl_r.rst_code)) * (TICK_CYCLES - 1))
    else $error("reset released early");

  a_factory_msb_kept: assert property (@(posedge mclk_i) disable iff (rst_i)
    ctrl_r.on_code[3] == FACTORY_ON_MSB && ctrl_r.off_code[3] == FACTORY_OFF_MSB)
    else $error("factory code bit changed");

  a_warn_select_map: assert property (@(posedge mclk_i) disable iff (rst_i)
    warn_select_o == psdt_pkg::thermal_warning_level_onehot(thermal_warning_level_o))
    else $error("warning select does not match level");

  a_timer_restart: assert property (@(posedge mclk_i) disable iff (rst_i)
    tmr_load |=> !tmr_done)
    else $error("delay not restarted on its event");

  a_irq_level_out: assert property (@(posedge mclk_i) disable iff (rst_i)
    irq_o == $past(|(irq_stat_r & irq_mask_r)))
    else $error("interrupt level mismatch");

endmodule

// ==== psdt_pkg.sv ====
// constants, types and decode functions shared by the power sequence delay timer
// assumes a 100 MHz mclk_i and a single 0.5 us timebase for every delay
package psdt_pkg;

  // clock and timebase
  localparam int CLK_PERIOD_NS = 10; // mclk_i period
  localparam int TICK_NS = 500; // timebase resolution, halves of a microsecond
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS; // default prescale
  localparam int US_TICKS = 1000 / TICK_NS; // ticks per microsecond
  localparam int TW = 17; // tick counter width, 80000 ticks max

  // delay figures, in their own units
  localparam int DLY_MIN_US_X10 = 285; // 28.5 us, codes 0000 and 0001
  localparam int DLY_SHORT_BASE_US = 114; // code 0010, doubles per step
  localparam int DLY_LONG_BASE_US = 500; // code 1001, doubles per step
  localparam int RST_BASE_MS = 5; // reset code 000, doubles to 011
  localparam int RST_HALF_MS_X10 = 5; // 0.5 ms
  localparam int RST_ONE_MS_X10 = 10; // 1.0 ms
  localparam int RST_2P5_MS_X10 = 25; // 2.5 ms
  localparam int POR_DELAY_US = 100; // own power-on clear hold
  localparam int POR_LIMIT_US = 800; // latest power-on clear release
  localparam int START_LIMIT_US = 1000; // latest first rail at zero delay
  localparam int DEEP_EXIT_LIMIT_MS = 1; // wake pin to first rail
  localparam int SLEEP_EXIT_LIMIT_US = 200; // exit command to first rail
  localparam int OFF_LIMIT_US = 200; // turn-off event to first rail off

  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CMD = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;

  // field positions
  localparam int CTRL_ON_LSB = 0; // startup code, 4 bits, top one fixed
  localparam int CTRL_OFF_LSB = 4; // turn-off code, 4 bits, top one fixed
  localparam int CTRL_RST_LSB = 8; // reset-release code, 3 bits
  localparam int CTRL_THERMAL_WARNING_LEVEL_LSB = 12; // warning level, 2 bits
  localparam int CMD_SLEEP_BIT = 0;
  localparam int CMD_DEEP_BIT = 1;
  localparam int CMD_EXIT_BIT = 2;

  // reset values
  localparam logic [2:0] ON_LOW_RST = 3'h0;
  localparam logic [2:0] OFF_LOW_RST = 3'h0;
  localparam logic [2:0] RST_CODE_RST = 3'h4;
  localparam logic [1:0] THERMAL_WARNING_LEVEL_RST = 2'h0;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // sequencer states
  typedef enum logic [2:0] {
    S_OFF, S_POR, S_ON_DLY, S_RST_DLY, S_ACTIVE, S_OFF_DLY, S_SLEEP, S_DEEP
  } psdt_state_t;

  // programmable settings
  typedef struct packed {
    logic [1:0] thermal_warning_level;
    logic [2:0] rst_code;
    logic [3:0] off_code;
    logic [3:0] on_code;
  } psdt_ctrl_t;

  // sticky event bits
  typedef struct packed {
    logic rst_released;
    logic rail_off;
    logic rail_on;
    logic por_done;
  } psdt_irq_t;

  // tenths of a microsecond to timebase ticks
  function automatic logic [TW-1:0] us_ticks(input int us_x10);
    return TW'(us_x10 * 100 / TICK_NS);
  endfunction

  // startup and turn-off codes share one table
  function automatic logic [TW-1:0] dly_ticks(input logic [3:0] code);
    if (!code[3]) begin
      if (code[2:1] == 2'h0) begin
        return us_ticks(DLY_MIN_US_X10);
      end
      return us_ticks(DLY_SHORT_BASE_US * 10) << 3'(code[2:0] - 3'h2);
    end
    if (code[2:0] == 3'h0) begin
      return '0;
    end
    return us_ticks(DLY_LONG_BASE_US * 10) << 3'(code[2:0] - 3'h1);
  endfunction

  // reset-release code; 111 falls back to the longest, 40 ms
  function automatic logic [TW-1:0] rst_ticks(input logic [2:0] code);
    unique case (code)
      3'h4: return us_ticks(RST_HALF_MS_X10 * 1000);
      3'h5: return us_ticks(RST_ONE_MS_X10 * 1000);
      3'h6: return us_ticks(RST_2P5_MS_X10 * 1000);
      3'h7: return us_ticks(RST_BASE_MS * 10000) << 3;
      default: return us_ticks(RST_BASE_MS * 10000) << code[1:0];
    endcase
  endfunction

  // warning level code to one-hot threshold select
  function automatic logic [3:0] thermal_warning_level_onehot(input logic [1:0] code);
    return 4'h1 << code;
  endfunction

endpackage

// ==== psdt_tick.sv ====
// timebase prescaler: one-cycle tick every TICK_CYCLES clocks
// assumes restart_i is a pulse from the sequencer when a delay is loaded
module psdt_tick #(
  parameter int TICK_CYCLES = psdt_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // control
  input wire logic restart_i,
  // timebase out
  output logic tick_o
);

  logic [15:0] cnt_r; // cycles since last tick

  // restart aligns the phase so a delay never loses a partial tick
  always_ff @(posedge mclk_i) begin
    if (rst_i || restart_i) begin
      cnt_r <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt_r == 16'(TICK_CYCLES - 1)) begin
      cnt_r <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick_o <= 1'b0;
    end
  end

endmodule

// ==== psdt_timer.sv ====
// loadable down counter on the shared timebase
// assumes tick_i is a one-cycle pulse; done_o holds until the next load
module psdt_timer (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // control
  input wire logic load_i,
  input wire logic [psdt_pkg::TW-1:0] load_val_i,
  input wire logic tick_i,
  // status
  output logic done_o
);

  logic [psdt_pkg::TW-1:0] cnt_r; // ticks still to wait
  logic busy_r; // delay in progress

  // load restarts the delay; a zero load finishes on the next edge
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      cnt_r <= load_val_i;
      busy_r <= 1'b1;
      done_o <= 1'b0;
    end else if (busy_r && cnt_r == '0) begin
      busy_r <= 1'b0;
      done_o <= 1'b1;
    end else if (busy_r && tick_i) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

endmodule

// ==== psdt_wake_model.sv ====
// wake pin model for the far side of the sequencer
// assumes one-cycle requests from the bench, synchronous to mclk_i
module psdt_wake_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // request from the bench
  input wire logic wake_req_i,
  // pin toward the device
  output logic wake_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // any edge wakes, so toggle: a pulse would give two events
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wake_pin_o <= 1'b0;
    end else if (wake_req_i) begin
      wake_pin_o <= ~wake_pin_o;
    end
  end
endmodule

// ==== testbench.sv ====
// self-checking bench for the sequencer, apb master and wake model
// assumes a shortened prescale; every delay bound scales with it
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 2; // prescale, clocks per tick
  localparam int US = TC * psdt_pkg::US_TICKS; // clocks per microsecond
  logic mclk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, uvlo = 0, wake_req = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, por, rail, sys_rst_n, deep, irq, wake_pin;
  logic [1:0] twl;
  logic [3:0] wsel;
  int failures = 0, num_checks = 0, n, m;
  wire logic [3:0] outs = {deep, sys_rst_n, rail, por}; // indexed by wait task
  always #5 mclk_i = ~mclk_i;
  psdt_seq #(.TICK_CYCLES(TC), .FACTORY_ON_MSB(1'b1), .FACTORY_OFF_MSB(1'b1)) DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .uvlo_ok_i(uvlo), .wake_pin_i(wake_pin),
    .por_released_o(por), .rail_on_o(rail), .system_reset_out_n_o(sys_rst_n),
    .deep_sleep_state_o(deep), .thermal_warning_level_o(twl), .warn_select_o(wsel),
    .irq_o(irq));
  psdt_wake_model u_wake (.mclk_i(mclk_i), .rst_i(rst_i), .wake_req_i(wake_req),
    .wake_pin_o(wake_pin));
  // value compare
  task check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bound compare: seen must not exceed limit
  task check_max(input string nm, input int lim, input int g);
    num_checks++;
    if (g > lim) begin
      failures++;
      $display("[FAIL] %s expected <= %0d seen %0d", nm, lim, g);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk_i);
    penable <= 1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // count clocks until an output reaches a level, capped past the limit
  task wait_for(input int s, input logic v, input int lim, output int c);
    c = 0;
    while (outs[s] !== v && c <= lim) begin
      @(posedge mclk_i);
      c++;
    end
  endtask
  // supply up with startup code 1000 (zero delay), reset code 100
  task t_power_up;
    apb(0, psdt_pkg::ADDR_CTRL, '0);
    check_val("ctrl reset", 32'h0000_0488, rd);
    uvlo <= 1;
    wait_for(0, 1, 800 * US, n);
    check_max("por release", 800 * US, n);
    wait_for(1, 1, 1000 * US, m);
    check_max("first rail", 1000 * US, n + m);
    wait_for(2, 1, 600 * US, n);
    check_max("reset late", 500 * US + TC + 4, n);
    check_max("reset early", n, 500 * US - 2);
  endtask
  // factory bits fixed; warning level select
  task t_ctrl;
    apb(1, psdt_pkg::ADDR_CTRL, 32'hFFFF_FFFF);
    apb(0, psdt_pkg::ADDR_CTRL, '0);
    check_val("ctrl fields", 32'h0000_37FF, rd);
    // delay tables in half-microsecond ticks
    check_val("on code 0001", 57, psdt_pkg::dly_ticks(4'h1));
    check_val("off code 0111", 7296, psdt_pkg::dly_ticks(4'h7));
    check_val("off code 1110", 32000, psdt_pkg::dly_ticks(4'hE));
    check_val("reset code 111", 80000, psdt_pkg::rst_ticks(3'h7));
    for (int k = 0; k < 4; k++) begin
      apb(1, psdt_pkg::ADDR_CTRL, 32'(k) << 12);
      repeat (2) @(posedge mclk_i);
      check_val("warn select", 32'h1 << k, {28'h0, wsel});
      check_val("warn level", k, {30'h0, twl});
    end
  endtask
  // sleep in and out by command, reset code 101
  task t_sleep;
    apb(1, psdt_pkg::ADDR_CTRL, 32'h0000_1500);
    apb(1, psdt_pkg::ADDR_CMD, 32'h1);
    wait_for(1, 0, 200 * US, n);
    check_max("sleep rail off", 200 * US, n);
    check_val("reset held", 0, {31'h0, sys_rst_n});
    apb(1, psdt_pkg::ADDR_CMD, 32'h4);
    wait_for(1, 1, 200 * US, n);
    check_max("sleep exit", 200 * US, n);
    wait_for(2, 1, 1100 * US, n);
    check_max("reset 1ms", 1000 * US + TC + 4, n);
    check_max("reset 1ms early", n, 1000 * US - 2);
  endtask
  // deep sleep with off code 1001, wake by pin
  task t_deep;
    apb(1, psdt_pkg::ADDR_CTRL, 32'h0000_1510);
    apb(1, psdt_pkg::ADDR_CMD, 32'h3);
    wait_for(1, 0, 600 * US, n);
    check_max("off delay", 500 * US + TC + 6, n);
    check_max("off early", n, 500 * US - 2);
    wait_for(3, 1, 10, n);
    check_val("deep state", 1, {31'h0, deep});
    @(posedge mclk_i) wake_req <= 1;
    @(posedge mclk_i) wake_req <= 0;
    wait_for(1, 1, 1000 * US, n);
    check_max("wake exit", 1000 * US, n);
  endtask
  // sticky events, mask, clear, unmapped place
  task t_irq;
    apb(0, psdt_pkg::ADDR_IRQ_STAT, '0);
    check_val("irq status", 32'hF, rd);
    check_val("irq masked", 0, {31'h0, irq});
    apb(1, psdt_pkg::ADDR_IRQ_MASK, 32'h4);
    repeat (2) @(posedge mclk_i);
    check_val("irq raised", 1, {31'h0, irq});
    apb(1, psdt_pkg::ADDR_IRQ_STAT, 32'hF);
    repeat (2) @(posedge mclk_i);
    check_val("irq cleared", 0, {31'h0, irq});
    apb(0, 12'h020, '0);
    check_val("unmapped err", 1, {31'h0, err});
  endtask
  // verdict and end of run
  task conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 0;
    t_power_up;
    t_ctrl;
    t_sleep;
    t_deep;
    t_irq;
    conclude;
  end
  // watchdog, well past the expected run of about 10000 clocks
  initial begin
    #600_000;
    failures++;
    conclude;
  end
endmodule
